/* File: verilog/cbf_pkg.sv */
// Shared types, constants and the mode decode function of the CAN receive buffer block
package cbf_pkg;

	localparam int ID_W = 29;
	localparam int NUM_FILTERS = 6;
	localparam int DATA_W = 64;

	// Filter and mask select codes on the configuration port
	localparam logic [3:0] SEL_FILTER_ZERO = 4'h0;
	localparam logic [3:0] SEL_FILTER_LAST = 4'h5;
	localparam logic [3:0] SEL_MASK_HIGH = 4'h6;
	localparam logic [3:0] SEL_MASK_LOW = 4'h7;

	// Filter hit codes
	localparam logic [2:0] HIT_HIGH_F0 = 3'h6;
	localparam logic [2:0] HIT_HIGH_F1 = 3'h7;
	localparam logic [2:0] HIT_ROLL_F0 = 3'h0;
	localparam logic [2:0] HIT_ROLL_F1 = 3'h1;
	localparam logic [2:0] HIT_LOW_F2 = 3'h2;

	// Transmit stuffing: complement after this many equal bits
	localparam logic [2:0] STUFF_LIMIT = 3'h5;

	// Quantum derivation: clocks per quantum = (prescaler + 1) * TQ_FIXED_DIV
	localparam int TQ_FIXED_DIV = 2;
	localparam logic [4:0] SYNC_SEG_TQ = 5'h01;

	// Reset values
	localparam logic [ID_W-1:0] MASK_RESET = 29'h0000000;
	localparam logic [7:0] ERR_COUNT_RESET = 8'h00;

	typedef enum logic [1:0] {
		MODE_FILTERED = 2'b00,
		MODE_STD_ONLY = 2'b01,
		MODE_EXT_ONLY = 2'b10,
		MODE_ANY_MSG = 2'b11
	} cbf_mode_t;

	typedef struct packed {
		logic ext;
		logic rtr;
		logic [ID_W-1:0] id;
		logic [3:0] dlc;
		logic [DATA_W-1:0] data;
	} cbf_frame_t;

	typedef struct packed {
		logic ext_id_select;
		logic [ID_W-1:0] id;
	} cbf_filter_t;

	typedef struct packed {
		logic rtr;
		logic [2:0] filter_hit_code;
	} cbf_ctrl_t;

	function automatic logic mode_admits(cbf_mode_t mode, logic ext);
		case (mode)
			MODE_STD_ONLY: mode_admits = !ext;
			MODE_EXT_ONLY: mode_admits = ext;
			default: mode_admits = 1'b1;
		endcase
	endfunction

endpackage

/* File: verilog/cbf_id_filter.sv */
// One acceptance filter: masked identifier compare plus format check
`timescale 1ns/1ps
module cbf_id_filter (
	input cbf_pkg::cbf_filter_t filter,
	input wire logic [cbf_pkg::ID_W-1:0] mask,
	input cbf_pkg::cbf_frame_t frame,
	input cbf_pkg::cbf_mode_t mode,
	output logic match
);
	import cbf_pkg::*;

	logic id_ok;

	// Mask bit 0 accepts, mask bit 1 needs equality; all bits must accept
	assign id_ok = &(~mask | ~(frame.id ^ filter.id));
	// A filter whose format disagrees with the frame or mode never matches
	assign match = id_ok && (filter.ext_id_select == frame.ext) &&
		mode_admits(mode, frame.ext);
endmodule

/* File: verilog/cbf_quantum_timer.sv */
// Time quantum prescaler and bit segment counter
`timescale 1ns/1ps
module cbf_quantum_timer (
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire logic [5:0] quantum_prescaler,
	input wire logic [2:0] prop_seg,
	input wire logic [2:0] phase_seg1,
	input wire logic [2:0] phase_seg2,
	output logic time_quantum,
	output logic sample_point,
	output logic bit_boundary
);
	import cbf_pkg::*;

	logic [6:0] div_count;
	logic [4:0] quanta;
	logic [6:0] div_last;
	logic [4:0] sample_q;
	logic [4:0] last_q;
	logic tq_end;

	// Prescaler values 0..63 give 1..64, then a fixed divide by two
	assign div_last = {quantum_prescaler, 1'b1};
	assign tq_end = run && (div_count == div_last);
	assign sample_q = SYNC_SEG_TQ + 5'(prop_seg) + 5'(phase_seg1) + 5'h01;
	assign last_q = sample_q + 5'(phase_seg2) + 5'h01;

	always_ff @(posedge clock) begin
		if (rst || !run || tq_end) begin
			div_count <= 7'h00;
		end else begin
			div_count <= div_count + 7'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || !run) begin
			quanta <= 5'h00;
		end else if (tq_end) begin
			quanta <= (quanta == last_q) ? 5'h00 : quanta + 5'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			time_quantum <= 1'b0;
			sample_point <= 1'b0;
			bit_boundary <= 1'b0;
		end else begin
			time_quantum <= tq_end;
			sample_point <= tq_end && (quanta == sample_q);
			bit_boundary <= tq_end && (quanta == last_q);
		end
	end

	a_tq_spacing: assert property (@(posedge clock)
		disable iff (rst) time_quantum |=> !time_quantum)
		else $error("quantum ticks closer than the fixed divide by two");
endmodule

/* File: verilog/cbf_rx_buffer_filter.sv */
// Receive buffers, acceptance filtering and transmit stuffing of the CAN block
`timescale 1ns/1ps
module cbf_rx_buffer_filter (
	input wire logic clock,
	input wire logic rst,
	input wire logic config_mode,
	input wire logic cfg_write,
	input wire logic [3:0] cfg_select,
	input wire logic [cbf_pkg::ID_W:0] cfg_wdata,
	output logic [cbf_pkg::ID_W:0] cfg_rdata,
	input wire logic frame_done,
	input wire logic frame_error,
	input cbf_pkg::cbf_frame_t assembly_buffer,
	input cbf_pkg::cbf_mode_t rx_accept_mode_high,
	input cbf_pkg::cbf_mode_t rx_accept_mode_low,
	input wire logic rollover_enable,
	input wire logic rx_full_irq_enable_high,
	input wire logic rx_full_irq_enable_low,
	input wire logic clear_full_high,
	input wire logic clear_full_low,
	input wire logic clear_overflow,
	output cbf_pkg::cbf_frame_t rx_buffer_high,
	output cbf_pkg::cbf_frame_t rx_buffer_low,
	output cbf_pkg::cbf_ctrl_t rx_high_control,
	output cbf_pkg::cbf_ctrl_t rx_low_control,
	output logic rx_full_flag_high,
	output logic rx_full_flag_low,
	output logic irq_high,
	output logic irq_low,
	output logic overflow_high,
	output logic overflow_low,
	output logic [7:0] rx_error_count,
	input wire logic [5:0] quantum_prescaler,
	input wire logic [2:0] prop_seg,
	input wire logic [2:0] phase_seg1,
	input wire logic [2:0] phase_seg2,
	output logic sample_point,
	input wire logic tx_bit,
	input wire logic tx_bit_valid,
	input wire logic tx_stuff_enable,
	output logic tx_bit_taken,
	output logic tx_line
);
	import cbf_pkg::*;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	cbf_filter_t filters [NUM_FILTERS];
	logic [ID_W-1:0] id_mask_high;
	logic [ID_W-1:0] id_mask_low;
	logic [NUM_FILTERS-1:0] hit;
	logic frame_taken;
	logic want_high;
	logic want_low;
	logic roll;
	logic load_high;
	logic load_low;
	logic ovf_high;
	logic ovf_low;
	logic [2:0] code_high;
	logic [2:0] code_low;
	logic time_quantum;
	logic bit_boundary;
	logic sample_unused;
	logic [2:0] run_len;

	// Lowest numbered matching filter inside a range wins
	function automatic logic [2:0] lowest_hit(logic [NUM_FILTERS-1:0] m,
		int first, int last);
		logic [2:0] code;
		code = 3'(first);
		for (int i = last; i >= first; i--) begin
			if (m[i]) begin
				code = 3'(i);
			end
		end
		return code;
	endfunction

	// Configuration mode gates all mask and filter writes
	always_ff @(posedge clock) begin
		if (rst) begin
			id_mask_high <= MASK_RESET;
			id_mask_low <= MASK_RESET;
			for (int i = 0; i < NUM_FILTERS; i++) begin
				filters[i] <= '0;
			end
		end else if (cfg_write && config_mode) begin
			if (cfg_select == SEL_MASK_HIGH) begin
				id_mask_high <= cfg_wdata[ID_W-1:0];
			end else if (cfg_select == SEL_MASK_LOW) begin
				id_mask_low <= cfg_wdata[ID_W-1:0];
			end else if (cfg_select <= SEL_FILTER_LAST) begin
				filters[cfg_select[2:0]] <= cfg_wdata;
			end
		end
	end

	// Read port shows zero outside configuration mode
	always_ff @(posedge clock) begin
		if (rst || !config_mode) begin
			cfg_rdata <= '0;
		end else if (cfg_select == SEL_MASK_HIGH) begin
			cfg_rdata <= {1'b0, id_mask_high};
		end else if (cfg_select == SEL_MASK_LOW) begin
			cfg_rdata <= {1'b0, id_mask_low};
		end else if (cfg_select <= SEL_FILTER_LAST) begin
			cfg_rdata <= filters[cfg_select[2:0]];
		end else begin
			cfg_rdata <= '0;
		end
	end

	// Filters 0-1 use the high mask and mode, 2-5 the low ones
	genvar g;
	generate
		for (g = 0; g < NUM_FILTERS; g++) begin : gen_filter
			cbf_id_filter u_filter (
				.filter(filters[g]),
				.mask((g < 2) ? id_mask_high : id_mask_low),
				.frame(assembly_buffer),
				.mode((g < 2) ? rx_accept_mode_high : rx_accept_mode_low),
				.match(hit[g])
			);
		end
	endgenerate

	// Acceptance decision; the assembly buffer itself is never exposed
	always_comb begin
		frame_taken = frame_done && !config_mode;
		want_high = frame_taken && (rx_accept_mode_high == MODE_ANY_MSG ||
			(!frame_error && (hit[0] || hit[1])));
		want_low = frame_taken && (rx_accept_mode_low == MODE_ANY_MSG ||
			(!frame_error && (|hit[5:2])));
		load_high = want_high && !rx_full_flag_high;
		roll = want_high && rx_full_flag_high && rollover_enable &&
			!rx_full_flag_low;
		load_low = roll || (!want_high && want_low && !rx_full_flag_low);
		ovf_high = want_high && rx_full_flag_high && !roll;
		ovf_low = !want_high && want_low && rx_full_flag_low;
		code_high = hit[0] ? HIT_HIGH_F0 :
			(hit[1] ? HIT_HIGH_F1 : HIT_HIGH_F0);
		if (roll) begin
			code_low = hit[0] ? HIT_ROLL_F0 :
				(hit[1] ? HIT_ROLL_F1 : HIT_ROLL_F0);
		end else begin
			code_low = lowest_hit(hit, 2, 5);
		end
	end

	// Whole frame copied on load, regardless of format or length
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_buffer_high <= '0;
			rx_high_control <= '0;
		end else if (load_high) begin
			rx_buffer_high <= assembly_buffer;
			rx_high_control <= {assembly_buffer.rtr, code_high};
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rx_buffer_low <= '0;
			rx_low_control <= '0;
		end else if (load_low) begin
			rx_buffer_low <= assembly_buffer;
			rx_low_control <= {assembly_buffer.rtr, code_low};
		end
	end

	// Full flags: a load in the clearing cycle keeps the flag set
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_full_flag_high <= 1'b0;
			rx_full_flag_low <= 1'b0;
		end else begin
			rx_full_flag_high <= load_high ||
				(rx_full_flag_high && !clear_full_high);
			rx_full_flag_low <= load_low ||
				(rx_full_flag_low && !clear_full_low);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_high <= 1'b0;
			irq_low <= 1'b0;
		end else begin
			irq_high <= rx_full_flag_high && rx_full_irq_enable_high;
			irq_low <= rx_full_flag_low && rx_full_irq_enable_low;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			overflow_high <= 1'b0;
			overflow_low <= 1'b0;
		end else begin
			overflow_high <= ovf_high || (overflow_high && !clear_overflow);
			overflow_low <= ovf_low || (overflow_low && !clear_overflow);
		end
	end

	// Receive error counter, cleared while configuring
	always_ff @(posedge clock) begin
		if (rst || config_mode) begin
			rx_error_count <= ERR_COUNT_RESET;
		end else if (frame_done && frame_error &&
			rx_error_count != 8'hFF) begin
			rx_error_count <= rx_error_count + 8'h01;
		end
	end

	cbf_quantum_timer u_timer (
		.clock(clock),
		.rst(rst),
		.run(!config_mode),
		.quantum_prescaler(quantum_prescaler),
		.prop_seg(prop_seg),
		.phase_seg1(phase_seg1),
		.phase_seg2(phase_seg2),
		.time_quantum(time_quantum),
		.sample_point(sample_unused),
		.bit_boundary(bit_boundary)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			sample_point <= 1'b0;
		end else begin
			sample_point <= sample_unused;
		end
	end

	// Stuffing keeps an edge on the bus at least every five bit times
	always_ff @(posedge clock) begin
		if (rst || config_mode) begin
			tx_line <= 1'b1;
			run_len <= 3'h0;
			tx_bit_taken <= 1'b0;
		end else if (bit_boundary) begin
			if (tx_stuff_enable && run_len == STUFF_LIMIT) begin
				tx_line <= !tx_line;
				run_len <= 3'h1;
				tx_bit_taken <= 1'b0;
			end else begin
				tx_line <= tx_bit_valid ? tx_bit : 1'b1;
				tx_bit_taken <= tx_bit_valid;
				if (!tx_stuff_enable ||
					(tx_bit_valid ? tx_bit : 1'b1) != tx_line) begin
					run_len <= 3'h1;
				end else begin
					run_len <= run_len + 3'h1;
				end
			end
		end else begin
			tx_bit_taken <= 1'b0;
		end
	end

	a_full_holds_buffer: assert property (
		rx_full_flag_high && !clear_full_high |=> $stable(rx_buffer_high))
		else $error("full high buffer was overwritten");
	a_load_copies_frame: assert property (
		load_low |=> rx_full_flag_low &&
		rx_buffer_low == $past(assembly_buffer))
		else $error("low buffer load lost frame or flag");
	a_irq_follows_flag: assert property (
		rx_full_flag_high && rx_full_irq_enable_high |=> irq_high)
		else $error("high buffer interrupt missing");
	a_config_reads_zero: assert property (
		!config_mode |=> cfg_rdata == '0)
		else $error("mask or filter visible outside configuration");
	a_config_no_rx: assert property (
		config_mode |-> !load_high && !load_low)
		else $error("frame stored in configuration mode");
	a_high_hit_code: assert property (
		load_high |=> rx_high_control.filter_hit_code[2:1] == 2'b11)
		else $error("high buffer hit code out of range");
	a_roll_codes_only: assert property (
		load_low && !rollover_enable |=>
		rx_low_control.filter_hit_code inside {[3'h2:3'h5]})
		else $error("rollover code without rollover");
	a_lowest_filter: assert property (
		load_low && !roll && hit[2] |=>
		rx_low_control.filter_hit_code == 3'h2)
		else $error("lower filter not preferred");
	a_rollover_path: assert property (
		want_high && rx_full_flag_high && rollover_enable && !rx_full_flag_low
		|-> load_low && !ovf_high)
		else $error("rollover did not reach low buffer");
	a_overflow_set: assert property (
		ovf_low |=> overflow_low && $stable(rx_buffer_low))
		else $error("dropped frame without overflow");
	a_stuff_run: assert property (
		run_len <= STUFF_LIMIT)
		else $error("stuff run too long");
	a_bit_on_quantum: assert property (
		bit_boundary |-> time_quantum)
		else $error("bit boundary off a quantum edge");
	c_load_high: cover property (@(posedge clock) disable iff (rst) load_high);
	c_rollover: cover property (@(posedge clock) disable iff (rst) roll);
	c_overflow: cover property (@(posedge clock) disable iff (rst) ovf_high);
	c_stuff_bit: cover property (@(posedge clock) disable iff (rst)
		bit_boundary && tx_stuff_enable && run_len == STUFF_LIMIT);
endmodule

/* File: verif/cbf_node_model.sv */
// Remote node model that delivers assembled frames to the receive block
`timescale 1ns/1ps
module cbf_node_model (
	input wire logic clock,
	output logic frame_done,
	output logic frame_error,
	output cbf_pkg::cbf_frame_t assembly_buffer
);
	import cbf_pkg::*;

	initial begin
		frame_done = 1'b0;
		frame_error = 1'b0;
		assembly_buffer = '0;
	end

	// One frame, one clock of frame_done; content is inverted afterwards
	task automatic send(input cbf_frame_t f, input logic err);
		@(posedge clock);
		#1;
		assembly_buffer = f;
		frame_error = err;
		frame_done = 1'b1;
		@(posedge clock);
		#1;
		frame_done = 1'b0;
		frame_error = 1'b0;
		assembly_buffer = ~f;
	endtask
endmodule

/* File: verif/cbf_rx_buffer_filter_tb_top.sv */
// Self-checking testbench of the CAN receive buffer block
`timescale 1ns/1ps
module cbf_rx_buffer_filter_tb_top;
	import cbf_pkg::*;
	typedef struct packed {
		logic hi;
		cbf_ctrl_t c;
		cbf_frame_t f;
	} cbf_note_t;
	logic clock = 0, rst = 1, config_mode = 0, cfg_write = 0;
	logic [3:0] cfg_select = 4'h0;
	logic [ID_W:0] cfg_wdata = '0, cfg_rdata;
	logic frame_done, frame_error, rollover_enable = 0;
	cbf_frame_t assembly_buffer, rx_buffer_high, rx_buffer_low;
	cbf_mode_t rx_accept_mode_high = MODE_FILTERED;
	cbf_mode_t rx_accept_mode_low = MODE_FILTERED;
	logic rx_full_irq_enable_high = 1, rx_full_irq_enable_low = 1;
	logic clear_full_high = 0, clear_full_low = 0, clear_overflow = 0;
	cbf_ctrl_t rx_high_control, rx_low_control;
	logic rx_full_flag_high, rx_full_flag_low, irq_high, irq_low;
	logic overflow_high, overflow_low, sample_point, tx_bit_taken, tx_line;
	logic [7:0] rx_error_count;
	logic [5:0] quantum_prescaler = 6'h00;
	logic [2:0] prop_seg = 3'h0, phase_seg1 = 3'h0, phase_seg2 = 3'h1;
	logic tx_bit = 0, tx_bit_valid = 0, tx_stuff_enable = 1;
	logic fh_q = 0, fl_q = 0;
	logic [28:0] fid [6];
	int fail_count = 0, num_checks = 0, n, bitlen;
	cbf_note_t notes [$];

	always #2 clock = ~clock;

	cbf_node_model node (.clock, .frame_done, .frame_error,
		.assembly_buffer);
	cbf_rx_buffer_filter uut (.clock, .rst, .config_mode, .cfg_write,
		.cfg_select, .cfg_wdata, .cfg_rdata, .frame_done, .frame_error,
		.assembly_buffer, .rx_accept_mode_high, .rx_accept_mode_low,
		.rollover_enable, .rx_full_irq_enable_high,
		.rx_full_irq_enable_low, .clear_full_high, .clear_full_low,
		.clear_overflow, .rx_buffer_high, .rx_buffer_low,
		.rx_high_control, .rx_low_control, .rx_full_flag_high,
		.rx_full_flag_low, .irq_high, .irq_low, .overflow_high,
		.overflow_low, .rx_error_count, .quantum_prescaler, .prop_seg,
		.phase_seg1, .phase_seg2, .sample_point, .tx_bit, .tx_bit_valid,
		.tx_stuff_enable, .tx_bit_taken, .tx_line);

	task automatic chk_val(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_rx(input logic hi, input cbf_ctrl_t c,
			input cbf_frame_t f);
		num_checks++;
		if (notes.size() == 0 || cbf_note_t'({hi, c, f}) !== notes[0]) begin
			fail_count++;
			$display("Error at %0t: unexpected receive load", $time);
		end
		if (notes.size() != 0) void'(notes.pop_front());
	endtask

	// Watches for each new load into either receive buffer
	always @(posedge clock) begin
		#1;
		if (!rst && rx_full_flag_high && !fh_q) begin
			chk_rx(1'b1, rx_high_control, rx_buffer_high);
		end
		if (!rst && rx_full_flag_low && !fl_q) begin
			chk_rx(1'b0, rx_low_control, rx_buffer_low);
		end
		fh_q = rx_full_flag_high;
		fl_q = rx_full_flag_low;
	end

	function automatic cbf_frame_t mk(input logic ext,
			input logic [28:0] id);
		mk.ext = ext;
		mk.rtr = 1'($urandom);
		mk.id = id;
		mk.dlc = 4'($urandom % 9);
		mk.data = {$urandom, $urandom};
	endfunction

	// Destination 0 none, 1 high buffer, 2 low buffer
	task automatic rx(input cbf_frame_t f, input logic err, input int dest,
			input logic [2:0] code);
		if (dest != 0) begin
			notes.push_back(cbf_note_t'({dest == 1, f.rtr, code, f}));
		end
		node.send(f, err);
		@(posedge clock);
		#1;
	endtask

	task automatic cfg(input logic [3:0] s, input logic [29:0] w);
		cfg_select = s;
		cfg_wdata = w;
		cfg_write = 1'b1;
		@(posedge clock);
		#1;
		cfg_write = 1'b0;
		@(posedge clock);
		#1;
	endtask

	task automatic rd(input logic [3:0] s, input logic [29:0] e);
		cfg_select = s;
		@(posedge clock);
		#1;
		chk_val(32'(cfg_rdata), 32'(e), "cfg read");
	endtask

	task automatic clr;
		clear_full_high = 1;
		clear_full_low = 1;
		clear_overflow = 1;
		@(posedge clock);
		#1;
		clear_full_high = 0;
		clear_full_low = 0;
		clear_overflow = 0;
	endtask

	// Counts cycles until the next sample point
	task automatic gap(output int k);
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (sample_point !== 1'b1 && k < 2000);
	endtask

	task automatic span(input logic lvl, output int k);
		k = 0;
		while (tx_line === lvl && k < 2000) begin
			@(posedge clock);
			#1;
			k++;
		end
	endtask

	task automatic print_verdict;
		$display("Checks %0d, errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		fail_count++;
		print_verdict;
	end

	initial begin
		void'($urandom(32'hAF240568));
		for (int i = 0; i < 6; i++) fid[i] = 29'($urandom);
		fid[0] = {11'($urandom), 18'h0};
		fid[1] = {11'($urandom), 18'h0};
		repeat (20) @(posedge clock);
		#1 rst = 0;
		chk_val({rx_full_flag_low, overflow_high, rx_error_count, tx_line},
			32'h1, "reset");
		config_mode = 1;
		for (int i = 0; i < 6; i++) cfg(4'(i), {i > 1, fid[i]});
		cfg(SEL_MASK_HIGH, 30'h1FF80000);
		cfg(SEL_MASK_LOW, 30'h1FFFFFFF);
		for (int i = 0; i < 6; i++) rd(4'(i), {i > 1, fid[i]});
		rd(SEL_MASK_HIGH, 30'h1FF80000);
		rd(4'h8, 30'h0);
		config_mode = 0;
		cfg(4'h0, 30'h3FFFFFFF);
		rd(SEL_MASK_LOW, 30'h0);
		rx(mk(0, fid[0] ^ 29'h40000), 0, 1, HIT_HIGH_F0);
		chk_val(irq_high, 1, "irq high");
		rx(mk(0, fid[1]), 0, 0, 0);
		chk_val(overflow_high, 1, "overflow");
		clr;
		rx(mk(0, fid[0] ^ 29'h80000), 0, 0, 0);
		chk_val(overflow_high, 0, "no overflow");
		rollover_enable = 1;
		rx(mk(0, fid[1]), 0, 1, HIT_HIGH_F1);
		rx(mk(0, fid[0]), 0, 2, HIT_ROLL_F0);
		chk_val(irq_low, 1, "irq low");
		rx(mk(0, fid[1]), 0, 0, 0);
		chk_val(overflow_high, 1, "roll full");
		clr;
		rollover_enable = 0;
		for (int i = 2; i < 6; i++) begin
			rx(mk(1, fid[i]), 0, 2, 3'(i));
			clr;
		end
		rx_accept_mode_low = MODE_STD_ONLY;
		rx(mk(1, fid[2]), 0, 0, 0);
		rx_accept_mode_low = MODE_EXT_ONLY;
		rx_full_irq_enable_low = 0;
		rx(mk(1, fid[3]), 0, 2, 3'h3);
		chk_val(irq_low, 0, "irq masked");
		rx_accept_mode_high = MODE_EXT_ONLY;
		rx(mk(0, fid[0]), 0, 0, 0);
		rx(mk(1, fid[2]), 0, 0, 0);
		chk_val(overflow_low, 1, "low overflow");
		clr;
		rx_accept_mode_low = MODE_FILTERED;
		rx_accept_mode_high = MODE_ANY_MSG;
		rx(mk(1, 29'($urandom)), 1, 1, HIT_HIGH_F0);
		clr;
		rx_accept_mode_high = MODE_FILTERED;
		rx(mk(0, fid[0]), 1, 0, 0);
		chk_val(32'(rx_error_count), 2, "error count");
		config_mode = 1;
		rx(mk(0, fid[0]), 0, 0, 0);
		chk_val(32'(rx_error_count), 0, "count in config");
		rd(4'h0, {1'b0, fid[0]});
		cfg(4'h5, {1'b1, fid[4]});
		config_mode = 0;
		rx(mk(1, fid[4]), 0, 2, 3'h4);
		clr;
		quantum_prescaler = 6'($urandom % 4);
		prop_seg = 3'($urandom);
		phase_seg1 = 3'($urandom);
		phase_seg2 = 3'($urandom);
		bitlen = 2 * (quantum_prescaler + 1) *
			(4 + prop_seg + phase_seg1 + phase_seg2);
		repeat (3) gap(n);
		chk_val(n, bitlen, "bit length");
		tx_bit_valid = 1;
		span(1, n);
		span(0, n);
		span(1, n);
		span(0, n);
		chk_val(n, 5 * bitlen, "stuffed run");
		chk_val(tx_bit_taken, 0, "stuff bit taken");
		span(1, n);
		chk_val(n, bitlen, "stuff bit length");
		chk_val(tx_bit_taken, 1, "data bit taken");
		tx_bit_valid = 0;
		chk_val(notes.size(), 0, "pending loads");
		print_verdict;
	end
endmodule
